// >>> l2fe_pkg.sv
// shared constants and state codes for the layer-2 learning and forwarding engine
package l2fe_pkg;

  // sizes
  localparam int NPORTS = 8;
  localparam int TBL_ENTRIES = 16;
  localparam int GRP_ENTRIES = 8;
  localparam int FRAME_DEPTH = 2048;
  localparam int FIFO_DEPTH = 32;

  // byte positions inside a frame handed over without its FCS
  localparam int OFF_DST = 0;
  localparam int OFF_SRC = 6;
  localparam int OFF_TYPE = 12;
  localparam int OFF_IPHDR = 14;
  localparam int OFF_IPPROTO = 23;
  localparam int IGMP_OFF_TYPE = 0;
  localparam int IGMP_OFF_GROUP = 4;
  localparam int IGMP_LEN = 8;
  localparam int MIN_FRAME = 14;

  // field values
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [7:0] IPPROTO_IGMP = 8'h02;
  localparam logic [7:0] IGMP_QUERY = 8'h11;
  localparam logic [7:0] IGMP_V2_REPORT = 8'h16;
  localparam logic [7:0] IGMP_V2_LEAVE = 8'h17;
  localparam logic [7:0] IGMP_V1_REPORT = 8'h12;
  localparam logic [31:0] GROUP_ANY = 32'h00000000;
  localparam logic [23:0] MCAST_OUI = 24'h01005E;

  // engine states, one-hot
  typedef enum logic [2:0] {
    ST_RX = 3'h1,
    ST_DECIDE = 3'h2,
    ST_TX = 3'h4
  } l2fe_state_e;

endpackage

// >>> l2fe_fifo.sv
// synchronous valid/ready fifo between the frame buffer and the egress ports
`timescale 1ns/100ps
`default_nettype none

module l2fe_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = l2fe_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic has_data;
  } l2fe_fifo_s;

  l2fe_fifo_s st;
  l2fe_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st.cnt != (PW+1)'(DEPTH));
  // registered so that valid leaves straight from a flip-flop
  assign out_valid = st.has_data;
  assign out_data = mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.has_data = (next_st.cnt != '0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage has no reset; only the pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wp] <= in_data;
    end
  end

endmodule
`default_nettype wire

// >>> l2fe_igmp_class.sv
// sorts an igmp message by its type code and group address
`timescale 1ns/100ps
`default_nettype none

module l2fe_igmp_class (
  // message fields
  input wire logic valid,
  input wire logic [7:0] msg_type,
  input wire logic [31:0] group,
  // kind of message
  output logic general_query,
  output logic group_query,
  output logic join_v1,
  output logic join_v2,
  output logic leave_v2
);

  always_comb begin
    general_query = 1'b0;
    group_query = 1'b0;
    join_v1 = 1'b0;
    join_v2 = 1'b0;
    leave_v2 = 1'b0;
    if (valid) begin
      unique case (msg_type)
        l2fe_pkg::IGMP_QUERY: begin
          general_query = (group == l2fe_pkg::GROUP_ANY);
          group_query = (group != l2fe_pkg::GROUP_ANY);
        end
        l2fe_pkg::IGMP_V2_REPORT: join_v2 = 1'b1;
        l2fe_pkg::IGMP_V1_REPORT: join_v1 = 1'b1;
        l2fe_pkg::IGMP_V2_LEAVE: leave_v2 = 1'b1;
        default: ;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> l2fe_engine.sv
// store-and-forward layer-2 learning, forwarding and igmp snooping engine
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module l2fe_engine #(
  parameter int NPORTS = l2fe_pkg::NPORTS,
  parameter int TBL_ENTRIES = l2fe_pkg::TBL_ENTRIES,
  parameter int GRP_ENTRIES = l2fe_pkg::GRP_ENTRIES,
  parameter int FRAME_DEPTH = l2fe_pkg::FRAME_DEPTH,
  parameter int FIFO_DEPTH = l2fe_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ingress byte stream from the port macs
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_err,
  input wire logic [$clog2(NPORTS)-1:0] in_port,
  output logic in_ready,
  // egress byte stream with destination port mask
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  output logic [NPORTS-1:0] out_mask,
  input wire logic out_ready
);

  localparam int PW = $clog2(NPORTS);
  localparam int AW = $clog2(FRAME_DEPTH) + 1;
  localparam int TW = $clog2(TBL_ENTRIES);
  localparam int GW = $clog2(GRP_ENTRIES);
  localparam int FW = 8 + 1 + NPORTS;
  localparam logic [NPORTS-1:0] ALL_PORTS = '1;

  typedef struct packed {
    logic valid;
    logic [47:0] mac;
    logic [PW-1:0] port;
  } l2fe_entry_s;

  typedef struct packed {
    logic valid;
    logic [47:0] mac;
    logic [NPORTS-1:0] members;
  } l2fe_group_s;

  typedef struct packed {
    l2fe_pkg::l2fe_state_e state;
    logic rx_open;
    logic [AW-1:0] cnt;
    logic [AW-1:0] rd;
    logic [PW-1:0] ing;
    logic err;
    logic [47:0] dst;
    logic [47:0] src;
    logic [15:0] etype;
    logic [3:0] ihl;
    logic [7:0] proto;
    logic [7:0] igtype;
    logic [31:0] iggrp;
    logic [NPORTS-1:0] mask;
    l2fe_entry_s [TBL_ENTRIES-1:0] tbl;
    logic [TW-1:0] tbl_ptr;
    l2fe_group_s [GRP_ENTRIES-1:0] grp;
    logic [GW-1:0] grp_ptr;
  } l2fe_state_s;

  l2fe_state_s st;
  l2fe_state_s next_st;
  logic [7:0] frame_buf [FRAME_DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // header parsing helpers

  logic rx_take;
  logic [AW-1:0] igmp_base;
  logic is_igmp;
  logic join1;
  logic join2;
  logic leave2;
  logic [47:0] grp_mac;

  assign rx_take = in_valid && st.rx_open;
  assign in_ready = st.rx_open;
  assign igmp_base = AW'(l2fe_pkg::OFF_IPHDR) + AW'({st.ihl, 2'b00});
  assign is_igmp = (st.etype == l2fe_pkg::ETYPE_IPV4) &&
                   (st.proto == l2fe_pkg::IPPROTO_IGMP) &&
                   (st.cnt >= igmp_base + AW'(l2fe_pkg::IGMP_LEN));
  assign grp_mac = {l2fe_pkg::MCAST_OUI, 1'b0, st.iggrp[22:0]};

  l2fe_igmp_class u_class (
    .valid(is_igmp),
    .msg_type(st.igtype),
    .group(st.iggrp),
    // queries are only forwarded, so their kind changes nothing here
    .general_query(),
    .group_query(),
    .join_v1(join1),
    .join_v2(join2),
    .leave_v2(leave2)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // table searches

  logic src_hit;
  logic [TW-1:0] src_idx;
  logic dst_hit;
  logic [PW-1:0] dst_port;
  logic mgrp_hit;
  logic [NPORTS-1:0] mgrp_members;
  logic rep_hit;
  logic [GW-1:0] rep_idx;

  always_comb begin
    src_hit = 1'b0;
    src_idx = '0;
    dst_hit = 1'b0;
    dst_port = '0;
    for (int i = 0; i < TBL_ENTRIES; i++) begin
      if (st.tbl[i].valid && st.tbl[i].mac == st.src && !src_hit) begin
        src_hit = 1'b1;
        src_idx = TW'(i);
      end
      if (st.tbl[i].valid && st.tbl[i].mac == st.dst && !dst_hit) begin
        dst_hit = 1'b1;
        dst_port = st.tbl[i].port;
      end
    end
  end

  always_comb begin
    mgrp_hit = 1'b0;
    mgrp_members = '0;
    rep_hit = 1'b0;
    rep_idx = '0;
    for (int i = 0; i < GRP_ENTRIES; i++) begin
      if (st.grp[i].valid && st.grp[i].mac == st.dst && !mgrp_hit) begin
        mgrp_hit = 1'b1;
        mgrp_members = st.grp[i].members;
      end
      if (st.grp[i].valid && st.grp[i].mac == grp_mac && !rep_hit) begin
        rep_hit = 1'b1;
        rep_idx = GW'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // forwarding decision

  logic good;
  logic [NPORTS-1:0] others;
  logic [NPORTS-1:0] fwd_mask;

  assign good = !st.err && (st.cnt >= AW'(l2fe_pkg::MIN_FRAME));
  assign others = ALL_PORTS & ~(NPORTS'(1) << st.ing);

  always_comb begin
    fwd_mask = '0;
    if (!good) begin
      fwd_mask = '0;
    end else if (&st.dst || is_igmp) begin
      // broadcast and snooped control frames reach every other port
      fwd_mask = others;
    end else if (st.dst[40]) begin
      // unknown groups have no members and go nowhere
      fwd_mask = mgrp_hit ? (mgrp_members & others) : '0;
    end else if (!dst_hit) begin
      fwd_mask = others;
    end else if (dst_port == st.ing) begin
      fwd_mask = '0;
    end else begin
      fwd_mask = NPORTS'(1) << dst_port;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // egress into the fifo

  logic fifo_in_ready;
  logic tx_push;
  logic tx_end;
  logic [FW-1:0] fifo_out;

  assign tx_push = (st.state == l2fe_pkg::ST_TX);
  assign tx_end = (st.rd == st.cnt - 1'b1);

  l2fe_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(tx_push),
    .in_data({st.mask, tx_end, frame_buf[st.rd[AW-2:0]]}),
    .in_ready(fifo_in_ready),
    .out_valid(out_valid),
    .out_data(fifo_out),
    .out_ready(out_ready)
  );

  assign out_data = fifo_out[7:0];
  assign out_last = fifo_out[8];
  assign out_mask = fifo_out[FW-1:9];

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    unique case (st.state)
      l2fe_pkg::ST_RX: begin
        if (rx_take) begin
          if (st.cnt == AW'(FRAME_DEPTH)) begin
            next_st.err = 1'b1;
          end else begin
            next_st.cnt = st.cnt + 1'b1;
          end
          if (st.cnt == '0) begin
            next_st.ing = in_port;
            // a short frame must not inherit the previous frame's protocol
            next_st.proto = '0;
          end
          if (st.cnt < AW'(l2fe_pkg::OFF_SRC)) begin
            next_st.dst = {st.dst[39:0], in_data};
          end else if (st.cnt < AW'(l2fe_pkg::OFF_TYPE)) begin
            next_st.src = {st.src[39:0], in_data};
          end else if (st.cnt < AW'(l2fe_pkg::OFF_IPHDR)) begin
            next_st.etype = {st.etype[7:0], in_data};
          end
          if (st.cnt == AW'(l2fe_pkg::OFF_IPHDR)) begin
            next_st.ihl = in_data[3:0];
          end
          if (st.cnt == AW'(l2fe_pkg::OFF_IPPROTO)) begin
            next_st.proto = in_data;
          end
          if (st.cnt == igmp_base + AW'(l2fe_pkg::IGMP_OFF_TYPE)) begin
            next_st.igtype = in_data;
          end
          if (st.cnt >= igmp_base + AW'(l2fe_pkg::IGMP_OFF_GROUP) &&
              st.cnt < igmp_base + AW'(l2fe_pkg::IGMP_LEN)) begin
            next_st.iggrp = {st.iggrp[23:0], in_data};
          end
          if (in_err) begin
            next_st.err = 1'b1;
          end
          if (in_last) begin
            next_st.rx_open = 1'b0;
            next_st.state = l2fe_pkg::ST_DECIDE;
          end
        end
      end
      l2fe_pkg::ST_DECIDE: begin
        next_st.mask = fwd_mask;
        next_st.rd = '0;
        // errored frames carry untrustworthy addresses, so they teach nothing
        if (good && !st.src[40]) begin
          if (src_hit) begin
            next_st.tbl[src_idx].port = st.ing;
          end else begin
            next_st.tbl[st.tbl_ptr] = '{valid: 1'b1, mac: st.src, port: st.ing};
            next_st.tbl_ptr = st.tbl_ptr + 1'b1;
          end
        end
        // reports add the ingress port; leaves remove it
        if (good && (join1 || join2)) begin
          if (rep_hit) begin
            next_st.grp[rep_idx].members = st.grp[rep_idx].members | ~others;
          end else begin
            next_st.grp[st.grp_ptr] = '{valid: 1'b1, mac: grp_mac, members: ~others};
            next_st.grp_ptr = st.grp_ptr + 1'b1;
          end
        end
        if (good && leave2 && rep_hit) begin
          next_st.grp[rep_idx].members = st.grp[rep_idx].members & others;
          if ((st.grp[rep_idx].members & others) == '0) begin
            next_st.grp[rep_idx].valid = 1'b0;
          end
        end
        if (fwd_mask == '0) begin
          next_st.state = l2fe_pkg::ST_RX;
          next_st.rx_open = 1'b1;
          next_st.cnt = '0;
          next_st.err = 1'b0;
        end else begin
          next_st.state = l2fe_pkg::ST_TX;
        end
      end
      l2fe_pkg::ST_TX: begin
        if (fifo_in_ready) begin
          next_st.rd = st.rd + 1'b1;
          if (tx_end) begin
            next_st.state = l2fe_pkg::ST_RX;
            next_st.rx_open = 1'b1;
            next_st.cnt = '0;
            next_st.err = 1'b0;
          end
        end
      end
      default: begin
        next_st.state = l2fe_pkg::ST_RX;
        next_st.rx_open = 1'b1;
        next_st.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.state <= l2fe_pkg::ST_RX;
      st.rx_open <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // frame storage, written while receiving; bytes past the end are dropped
  always_ff @(posedge clk) begin
    if (rx_take && st.cnt < AW'(FRAME_DEPTH)) begin
      frame_buf[st.cnt[AW-2:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

// >>> l2fe_engine_asserts.sv
// concurrent checks on the ports of the forwarding engine
`timescale 1ns/100ps
`default_nettype none

module l2fe_engine_asserts #(
  parameter int NPORTS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ingress
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_err,
  input wire logic [$clog2(NPORTS)-1:0] in_port,
  input wire logic in_ready,
  // egress
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic [NPORTS-1:0] out_mask,
  input wire logic out_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // only the difference of the two frame counters matters, so wrapping is harmless
  logic [15:0] taken, started, out_cnt;
  logic busy;
  logic [NPORTS-1:0] fmask;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      taken <= 16'h0;
      started <= 16'h0;
      out_cnt <= 16'h0;
      busy <= 1'b0;
      fmask <= '0;
    end else begin
      if (in_valid && in_ready && in_last) taken <= taken + 16'h1;
      if (out_valid && out_ready) begin
        if (!busy) started <= started + 16'h1;
        if (!busy) fmask <= out_mask;
        busy <= !out_last;
        out_cnt <= out_last ? 16'h0 : out_cnt + 16'h1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence stalled_s; out_valid && !out_ready; endsequence
  sequence last_taken_s; in_valid && in_ready && in_last; endsequence
  sequence first_byte_s; out_valid && !busy; endsequence
  reset_idle_a: assert property ($rose(nrst) |-> in_ready && !out_valid)
    else $error("engine not idle after reset");
  stall_valid_a: assert property (stalled_s |=> out_valid)
    else $error("egress byte withdrawn while stalled");
  stall_data_a: assert property (stalled_s |=> $stable(out_data) && $stable(out_last))
    else $error("egress byte changed while stalled");
  mask_const_a: assert property (out_valid && busy |-> out_mask == fmask)
    else $error("egress mask changed inside a frame");
  mask_nonzero_a: assert property (out_valid |-> |out_mask)
    else $error("egress frame with empty mask");
  ready_drop_a: assert property (last_taken_s |=> !in_ready)
    else $error("ingress still ready after last byte");
  store_first_a: assert property (first_byte_s |-> started != taken)
    else $error("egress started before a frame was stored");
  no_runt_a: assert property (out_valid && out_ready && out_last |-> out_cnt >= 16'hD)
    else $error("runt frame forwarded");
endmodule

bind l2fe_engine l2fe_engine_asserts #(.NPORTS(NPORTS)) chk (.clk(clk), .nrst(nrst),
  .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_err(in_err),
  .in_port(in_port), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
  .out_last(out_last), .out_mask(out_mask), .out_ready(out_ready));
`default_nettype wire

// >>> l2fe_port_sink.sv
// egress port model: takes bytes, stalls one cycle in four when slow, keeps whole frames
`timescale 1ns/100ps
`default_nettype none

module l2fe_port_sink (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // stall select
  input wire logic slow,
  // egress stream
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic [7:0] out_mask,
  output logic out_ready
);
  logic [7:0] data_q[$];
  logic [7:0] mask_q[$];
  int len_q[$];
  int cnt;
  logic [1:0] ph;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph <= 2'h0;
      cnt = 0;
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        data_q.push_back(out_data);
        cnt++;
        if (out_last) begin
          // length is pushed last so a reader never sees a partial frame
          mask_q.push_back(out_mask);
          len_q.push_back(cnt);
          cnt = 0;
        end
      end
      ph <= ph + 2'h1;
      out_ready <= !slow || ph != 2'h2;
    end
  end
endmodule
`default_nettype wire

// >>> l2fe_engine_bench.sv
// self-checking bench for the learning and forwarding engine
`timescale 1ns/100ps
`default_nettype none

module l2fe_engine_bench;
  logic clk, nrst, in_valid, in_last, in_err, in_ready, out_valid, out_last, out_ready, slow;
  logic [7:0] in_data, out_data, out_mask;
  logic [2:0] in_port;
  logic [7:0] fr[$];
  int fail_count, total_checks;
  localparam logic [47:0] MAC_A = 48'h02AA00000001;
  localparam logic [47:0] MAC_B = 48'h02BB00000002;
  localparam logic [47:0] MAC_C = 48'h02CC00000003;
  localparam logic [47:0] MAC_D = 48'h02DD00000004;
  localparam logic [31:0] GRP = 32'hEF010203;

  l2fe_engine dut (.clk(clk), .nrst(nrst), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_err(in_err), .in_port(in_port), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_mask(out_mask),
    .out_ready(out_ready));
  l2fe_port_sink sink (.clk(clk), .nrst(nrst), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_mask(out_mask), .out_ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_num(string what, int exp, int got);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic send(logic [2:0] port, logic err);
    int n;
    for (int i = 0; i < fr.size(); i++) begin
      in_valid = 1'b1;
      in_data = fr[i];
      in_last = (i == fr.size() - 1);
      in_err = err && (i == fr.size() - 1);
      in_port = port;
      n = 0;
      while (in_ready !== 1'b1 && n < 5000) begin
        @(posedge clk);
        #1;
        n++;
      end
      @(posedge clk);
      #1;
    end
    in_valid = 1'b0;
    in_last = 1'b0;
    in_err = 1'b0;
  endtask
  task automatic eth(logic [47:0] dst, logic [47:0] src, logic [15:0] et);
    fr = {};
    for (int i = 40; i >= 0; i -= 8) fr.push_back(dst[i+:8]);
    for (int i = 40; i >= 0; i -= 8) fr.push_back(src[i+:8]);
    fr = {fr, et[15:8], et[7:0]};
  endtask
  task automatic data(logic [47:0] dst, logic [47:0] src);
    eth(dst, src, 16'h88B5);
    for (int i = 0; i < 46; i++) fr.push_back(8'(i));
  endtask
  task automatic igmp(logic [7:0] typ, logic [31:0] grp, logic [31:0] ipd, logic [47:0] src);
    // each message goes to the ipd address with time-to-live 1
    eth({l2fe_pkg::MCAST_OUI, 1'b0, ipd[22:0]}, src, l2fe_pkg::ETYPE_IPV4);
    fr = {fr, 8'h45, 8'h00, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    fr = {fr, 8'h0A, 8'h0A, 8'h0A, 8'h0A, ipd[31:24], ipd[23:16], ipd[15:8], ipd[7:0]};
    fr = {fr, typ, 8'h64, 8'h00, 8'h00, grp[31:24], grp[23:16], grp[15:8], grp[7:0]};
  endtask
  task automatic expect_frame(logic [7:0] mask);
    int n;
    n = 0;
    while (sink.len_q.size() == 0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_num("frame count", 1, sink.len_q.size());
    if (sink.len_q.size() == 0) return;
    check8("egress mask", mask, sink.mask_q.pop_front());
    check_num("frame length", fr.size(), sink.len_q.pop_front());
    foreach (fr[i]) check8("egress byte", fr[i], sink.data_q.pop_front());
  endtask
  task automatic expect_none();
    repeat (300) @(posedge clk);
    #1;
    check_num("frame count", 0, sink.len_q.size());
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_unicast();
    data(MAC_B, MAC_A);
    send(3'h1, 1'b0);
    expect_frame(8'hFD);
    data(MAC_A, MAC_B);
    send(3'h2, 1'b0);
    expect_frame(8'h02);
    slow = 1'b1;
    data(MAC_B, MAC_A);
    send(3'h1, 1'b0);
    expect_frame(8'h04);
    slow = 1'b0;
    data(MAC_A, MAC_C);
    send(3'h1, 1'b0);
    expect_none();
  endtask
  task automatic t_error();
    data(MAC_A, MAC_D);
    send(3'h3, 1'b1);
    expect_none();
    data(MAC_A, MAC_D);
    fr = fr[0:9];
    send(3'h3, 1'b0);
    expect_none();
    data(MAC_D, MAC_B);
    send(3'h4, 1'b0);
    expect_frame(8'hEF);
    data(48'hFFFFFFFFFFFF, MAC_D);
    send(3'h6, 1'b0);
    expect_frame(8'hBF);
  endtask
  task automatic t_move();
    data(MAC_B, MAC_A);
    send(3'h5, 1'b0);
    expect_frame(8'h10);
    data(MAC_A, MAC_B);
    send(3'h2, 1'b0);
    expect_frame(8'h20);
  endtask
  task automatic igmp_step(logic [2:0] port, logic [7:0] typ, logic [31:0] grp,
      logic [31:0] ipd, logic [7:0] members);
    igmp(typ, grp, ipd, {40'h02EE000000, 5'h0, port});
    send(port, 1'b0);
    expect_frame(~(8'h01 << port));
    data({l2fe_pkg::MCAST_OUI, 1'b0, GRP[22:0]}, MAC_C);
    send(3'h0, 1'b0);
    expect_frame(members);
  endtask
  task automatic t_igmp();
    igmp_step(3'h3, l2fe_pkg::IGMP_V2_REPORT, GRP, GRP, 8'h08);
    igmp_step(3'h6, l2fe_pkg::IGMP_V1_REPORT, GRP, GRP, 8'h48);
    igmp_step(3'h7, l2fe_pkg::IGMP_QUERY, l2fe_pkg::GROUP_ANY, 32'hE0000001, 8'h48);
    igmp_step(3'h7, l2fe_pkg::IGMP_QUERY, GRP, GRP, 8'h48);
    igmp_step(3'h3, l2fe_pkg::IGMP_V2_LEAVE, GRP, 32'hE0000002, 8'h40);
    // no port joined the group 01005E090909, so a frame sent to it goes nowhere
    data({l2fe_pkg::MCAST_OUI, 24'h090909}, MAC_C);
    send(3'h0, 1'b0);
    expect_none();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    in_err = 1'b0;
    in_port = 3'h0;
    slow = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_unicast();
    t_error();
    t_move();
    t_igmp();
    end_sim();
  end
  initial begin
    // about 100k cycles, more than twenty times what the frames above need
    #1000000;
    fail_count++;
    $display("BAD watchdog expected done seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
